/* File: src/idp_buf.sv */
`timescale 1ns/1ns
module idp_buf (
    // clock
    input wire logic sys_clk,
    input wire logic sys_rst,
    // write side
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [15:0] wdata,
    // read side
    input wire logic re,
    input wire logic [7:0] raddr,
    output logic [15:0] rdata_ff
);
    logic [15:0] mem [0:255];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_ff <= 16'h0000;
        end else if (re) begin
            rdata_ff <= mem[raddr];
        end
    end
endmodule

/* File: src/idp_pkg.sv */
package idp_pkg;

    localparam logic [7:0] IDP_CMD_IDENTIFY = 8'hec;
    localparam logic [7:0] IDP_LAST_WORD = 8'hff;
    localparam logic [7:0] IDP_SPACE = 8'h20;

    // fixed word values
    localparam logic [15:0] IDP_W0_CONFIG = 16'h045a;
    localparam logic [15:0] IDP_W1_CYLS = 16'h3fff;
    localparam logic [15:0] IDP_W3_HEADS = 16'h0010;
    localparam logic [15:0] IDP_W6_SPT = 16'h003f;
    localparam logic [15:0] IDP_W20_OLD = 16'h0003;
    localparam logic [15:0] IDP_W21_BUFSZ = 16'h0400;
    localparam logic [15:0] IDP_W22_ECC = 16'h0004;
    localparam logic [15:0] IDP_W47_MULTMAX = 16'h8010;
    localparam logic [15:0] IDP_W49_CAPS = 16'h2b00;
    localparam logic [15:0] IDP_W50_CAPS = 16'h4000;
    localparam logic [15:0] IDP_W51_PIO = 16'h0200;
    localparam logic [15:0] IDP_W52_SWDMA = 16'h0200;
    localparam logic [15:0] IDP_W53_VALID = 16'h0007;
    localparam logic [7:0] IDP_W63_MDMA_SUP = 8'h07;
    localparam logic [15:0] IDP_W64_APIO = 16'h0003;
    localparam logic [15:0] IDP_W65_MDMA_MIN = 16'h0078;
    localparam logic [15:0] IDP_W66_MDMA_REC = 16'h0078;
    localparam logic [15:0] IDP_W67_PIO_NOFC = 16'h00f0;
    localparam logic [15:0] IDP_W68_PIO_FC = 16'h0078;
    localparam logic [15:0] IDP_W80_MAJOR = 16'h003e;
    localparam logic [15:0] IDP_W81_MINOR = 16'h0015;
    localparam logic [15:0] IDP_W82_CMDSET = 16'h346b;
    localparam logic [15:0] IDP_W83_CMDSET = 16'h4108;
    localparam logic [15:0] IDP_W84_EXT = 16'h4000;
    localparam logic [15:0] IDP_W87_DEFAULT = 16'h4000;
    localparam logic [7:0] IDP_W88_UDMA_SUP = 8'h3f;
    localparam logic [15:0] IDP_W90_ENH_ERASE = 16'h0000;

    // string fields: first word and width in characters
    localparam logic [7:0] IDP_SERIAL_W0 = 8'h0a;
    localparam logic [7:0] IDP_SERIAL_WN = 8'h13;
    localparam logic [5:0] IDP_SERIAL_LEN = 6'h14;
    localparam logic [7:0] IDP_FW_W0 = 8'h17;
    localparam logic [7:0] IDP_FW_WN = 8'h1a;
    localparam logic [5:0] IDP_FW_LEN = 6'h08;
    localparam logic [7:0] IDP_MODEL_W0 = 8'h1b;
    localparam logic [7:0] IDP_MODEL_WN = 8'h2e;
    localparam logic [5:0] IDP_MODEL_LEN = 6'h28;

    typedef enum logic [2:0] {
        IDP_IDLE = 3'b001,
        IDP_FILL = 3'b010,
        IDP_XFER = 3'b100
    } idp_state_e;

    typedef struct packed {
        logic [15:0] cur_cyl;
        logic [15:0] cur_head;
        logic [15:0] cur_spt;
        logic [31:0] cur_cap;
        logic [7:0] multi_cnt;
        logic [31:0] lba_cap;
        logic mdma_en;
        logic [1:0] mdma_mode;
        logic udma_en;
        logic [2:0] udma_mode;
        logic [7:0] apm_level;
        logic [15:0] erase_time;
    } idp_cfg_s;

    typedef struct packed {
        logic [319:0] model;
        logic [5:0] model_len;
        logic [63:0] fw;
        logic [5:0] fw_len;
        logic [159:0] serial;
        logic [5:0] serial_len;
    } idp_str_s;

endpackage

/* File: src/idp_top.sv */
`timescale 1ns/1ns
// Summary of operation
// RL1: word 0 reads 045a, fixed ATA device
// RL2: default geometry 3fff cylinders, 10 heads, 3f
// RL3: serial number words 10-19, right justified
// RL4: firmware revision words 23-26, left justified
// RL5: model words 27-46, left justified, space padded
// RL6: buffer size 0400 and ecc bytes 0004
// RL7: word 47 reads 8010, multiple limit
// RL8: word 49 capabilities read 2b00
// RL9: pio and single dma timing words 0200
// RL10: word 53 reads 0007, validity flags
// RL11: current geometry and capacity words track translation
// RL12: word 59 multiple count, only 2/4/8/16
// RL13: words 60-61 give lba sector count
// RL14: word 63 low byte reads 07
// RL15: word 64 reads 0003, pio 3 and 4
// RL16: words 65-66 read 0078, 120 ns
// RL17: words 67 and 68 read 00f0, 0078
// RL18: version words 80, 81 read 003e, 0015
// RL19: command set words 346b, 4108, 4000, 4000
// RL20: words 89-91: erase time, zero, apm level
// RL21: identify: busy, fill page, then drq, interrupt
// RL22: word 63 bits 10-8 flag selected mode
// RL23: word 88 udma supported and selected mode
// RL24: retired and reserved words read zero
// RL25: first string character in high byte
module idp_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // command in
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    // drive settings
    input wire idp_pkg::idp_cfg_s cfg,
    input wire idp_pkg::idp_str_s str,
    // host word read
    input wire logic rd_req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // status
    output logic busy,
    output logic drq,
    output logic irq
);
    import idp_pkg::*;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    idp_state_e state_ff;
    idp_state_e nxt_state;
    logic [7:0] fill_idx_ff;
    logic [7:0] rd_ptr_ff;
    logic irq_ff;
    logic rd_valid_ff;
    logic [15:0] gen_word;

    logic cmd_acc;
    logic fill_last;
    logic rd_acc;
    logic rd_last;

    // other commands belong to other blocks; ours only while idle
    assign cmd_acc = (state_ff == IDP_IDLE) && cmd_valid && (cmd_code == IDP_CMD_IDENTIFY);
    assign fill_last = (state_ff == IDP_FILL) && (fill_idx_ff == IDP_LAST_WORD);
    assign rd_acc = (state_ff == IDP_XFER) && rd_req;
    assign rd_last = rd_acc && (rd_ptr_ff == IDP_LAST_WORD);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IDP_IDLE: begin
                if (cmd_acc) begin
                    nxt_state = IDP_FILL; // RL21
                end
            end
            IDP_FILL: begin
                if (fill_last) begin
                    nxt_state = IDP_XFER; // RL21
                end
            end
            IDP_XFER: begin
                if (rd_last) begin
                    nxt_state = IDP_IDLE; // RL21
                end
            end
            default: nxt_state = IDP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= IDP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // page fill

    // settings are sampled word by word during the fill, not frozen at the command
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fill_idx_ff <= 8'h00;
        end else if (state_ff == IDP_FILL) begin
            fill_idx_ff <= 8'(fill_idx_ff + 8'h01); // RL21
        end else begin
            fill_idx_ff <= 8'h00;
        end
    end

    idp_word_gen u_gen (
        .idx(fill_idx_ff),
        .cfg(cfg),
        .str(str),
        .word(gen_word)
    );

    idp_buf u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .we(state_ff == IDP_FILL),
        .waddr(fill_idx_ff),
        .wdata(gen_word),
        .re(rd_acc),
        .raddr(rd_ptr_ff),
        .rdata_ff(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt and host read

    // one-cycle pulse as the page becomes readable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= fill_last; // RL21
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_ptr_ff <= 8'h00;
        end else if (state_ff != IDP_XFER) begin
            rd_ptr_ff <= 8'h00;
        end else if (rd_acc) begin
            rd_ptr_ff <= 8'(rd_ptr_ff + 8'h01); // RL21
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_acc;
        end
    end

    assign busy = (state_ff == IDP_FILL); // RL21
    assign drq = (state_ff == IDP_XFER); // RL21
    assign irq = irq_ff;
    assign rd_valid = rd_valid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic wr_en;
    assign wr_en = (state_ff == IDP_FILL);

    sequence s_busy_run;
        (busy && !drq) [*8];
    endsequence

    sequence s_page_ready;
        drq && irq && !busy;
    endsequence

    a_busy_on_cmd: assert property ( // RL21
        @(posedge sys_clk) disable iff (sys_rst)
        cmd_acc |=> s_busy_run)
    else $error("busy not held after identify command");

    a_drq_after_fill: assert property ( // RL21
        @(posedge sys_clk) disable iff (sys_rst)
        cmd_acc |-> ##257 s_page_ready)
    else $error("drq and interrupt not raised after page fill");

    a_irq_single: assert property ( // RL21
        @(posedge sys_clk) disable iff (sys_rst)
        irq |=> !irq)
    else $error("interrupt wider than one cycle");

    a_word0_config: assert property ( // RL1
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd0 |-> gen_word == 16'h045a)
    else $error("word 0 wrong");

    a_geometry_words: assert property ( // RL2
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd1 |-> gen_word == 16'h3fff
            ##2 gen_word == 16'h0010 ##3 gen_word == 16'h003f)
    else $error("default geometry words wrong");

    a_caps_words: assert property ( // RL8
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd49 |-> gen_word == 16'h2b00
            ##2 gen_word == 16'h0200 ##1 gen_word == 16'h0200 ##1 gen_word == 16'h0007)
    else $error("capability or timing words wrong");

    a_mdma_select: assert property ( // RL22
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd63 |-> $onehot0(gen_word[10:8])
            && gen_word[7:0] == 8'h07 && gen_word[15:11] == 5'h00)
    else $error("word 63 select or support wrong");

    a_udma_select: assert property ( // RL23
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd88 |-> $onehot0(gen_word[13:8])
            && gen_word[7:0] == 8'h3f)
    else $error("word 88 select or support wrong");

    a_multi_count: assert property ( // RL12
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd59 && gen_word[8] |->
            gen_word[7:0] inside {8'h02, 8'h04, 8'h08, 8'h10})
    else $error("illegal multiple count reported");

    a_cycle_times: assert property ( // RL16
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd65 |-> gen_word == 16'h0078
            ##1 gen_word == 16'h0078 ##1 gen_word == 16'h00f0 ##1 gen_word == 16'h0078)
    else $error("cycle time words wrong");

    a_reserved_zero: assert property ( // RL24
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && (fill_idx_ff inside {[8'd69:8'd79], 8'd92, [8'd95:8'd127],
            [8'd129:8'd255]}) |-> gen_word == 16'h0000)
    else $error("reserved word not zero");

    a_model_padding: assert property ( // RL5
        @(posedge sys_clk) disable iff (sys_rst)
        wr_en && fill_idx_ff == 8'd46 && str.model_len <= 6'd38 |-> gen_word == 16'h2020)
    else $error("model field not blank padded");

    a_read_latency: assert property ( // RL21
        @(posedge sys_clk) disable iff (sys_rst)
        rd_acc |=> rd_valid ##0 (drq || $past(rd_last)))
    else $error("read data not returned next cycle");

    a_xfer_end: assert property ( // RL21
        @(posedge sys_clk) disable iff (sys_rst)
        rd_last |=> !drq && !busy)
    else $error("drq not dropped after last word");

    a_serial_blank: assert property ( // RL3
        wr_en && fill_idx_ff == 8'd10
            && str.serial_len <= 6'd18
            |-> gen_word == 16'h2020)
    else $error("serial not right justified");

    a_fw_blank: assert property ( // RL4
        wr_en && fill_idx_ff == 8'd26
            && str.fw_len <= 6'd6
            |-> gen_word == 16'h2020)
    else $error("firmware not padded");

    a_buf_ecc: assert property ( // RL6
        wr_en && fill_idx_ff == 8'd21
            |-> gen_word == 16'h0400
            ##1 gen_word == 16'h0004)
    else $error("buffer or ecc word wrong");

    a_multi_max: assert property ( // RL7
        wr_en && fill_idx_ff == 8'd47
            |-> gen_word == 16'h8010)
    else $error("word 47 wrong");

    a_cur_geometry: assert property ( // RL11
        wr_en && fill_idx_ff == 8'd54
            |-> gen_word == cfg.cur_cyl
            ##1 gen_word == cfg.cur_head
            ##1 gen_word == cfg.cur_spt
            ##1 gen_word == cfg.cur_cap[15:0]
            ##1 gen_word == cfg.cur_cap[31:16])
    else $error("current geometry wrong");

    a_lba_count: assert property ( // RL13
        wr_en && fill_idx_ff == 8'd60
            |-> gen_word == cfg.lba_cap[15:0]
            ##1 gen_word == cfg.lba_cap[31:16])
    else $error("lba count wrong");

    a_adv_pio: assert property ( // RL15
        wr_en && fill_idx_ff == 8'd64
            |-> gen_word == 16'h0003)
    else $error("word 64 wrong");

    a_version_sets: assert property ( // RL18 RL19
        wr_en && fill_idx_ff == 8'd80
            |-> gen_word == 16'h003e
            ##1 gen_word == 16'h0015
            ##1 gen_word == 16'h346b
            ##1 gen_word == 16'h4108
            ##1 gen_word == 16'h4000)
    else $error("version words wrong");

    a_power_words: assert property ( // RL19 RL20
        wr_en && fill_idx_ff == 8'd87
            |-> gen_word == 16'h4000
            ##2 gen_word == cfg.erase_time
            ##1 gen_word == 16'h0000
            ##1 gen_word == {8'h00, cfg.apm_level})
    else $error("words 87 to 91 wrong");

    a_retired_zero: assert property ( // RL24
        wr_en && (fill_idx_ff inside {8'd2, 8'd4, 8'd5,
            [8'd7:8'd9], 8'd48, 8'd62}) |-> gen_word == 16'h0000)
    else $error("retired word not zero");

    a_valid_source: assert property ( // RL21
        rd_valid |-> $past(rd_acc))
    else $error("data without a read");

    a_data_hold: assert property ( // RL21
        !rd_acc |=> $stable(rd_data))
    else $error("data changed without a read");

    a_idle_refuse: assert property ( // RL21
        state_ff == IDP_IDLE && !cmd_acc
            |=> !busy && !drq)
    else $error("left idle without identify");

    a_irq_at_ready: assert property ( // RL21
        irq |-> drq && !busy)
    else $error("interrupt outside page ready");

endmodule

/* File: src/idp_word_gen.sv */
`timescale 1ns/1ns
module idp_word_gen (
    // word select
    input wire logic [7:0] idx,
    // live settings
    input wire idp_pkg::idp_cfg_s cfg,
    input wire idp_pkg::idp_str_s str,
    // page word
    output logic [15:0] word
);
    import idp_pkg::*;

    // blank outside the text, right or left justified
    function automatic logic [7:0] fld_char(input logic [319:0] text, input logic [5:0] len,
                                            input logic [5:0] width, input logic [5:0] pos,
                                            input logic right);
        logic [5:0] l;
        logic [5:0] off;
        logic [5:0] p;
        l = (len > width) ? width : len;
        off = right ? 6'(width - l) : 6'h00;
        p = 6'(pos - off);
        if (pos < off || p >= l) begin
            return IDP_SPACE;
        end
        return text[9'(p) * 9'd8 +: 8];
    endfunction

    logic [5:0] pos;
    logic is_multi_ok;

    always_comb begin
        pos = 6'h00;
        is_multi_ok = cfg.multi_cnt inside {8'h02, 8'h04, 8'h08, 8'h10}; // RL12
        word = 16'h0000; // RL24
        if (idx >= IDP_SERIAL_W0 && idx <= IDP_SERIAL_WN) begin
            pos = 6'({idx - IDP_SERIAL_W0, 1'b0});
            word = {fld_char({160'h0, str.serial}, str.serial_len, IDP_SERIAL_LEN, pos, 1'b1),
                    fld_char({160'h0, str.serial}, str.serial_len, IDP_SERIAL_LEN,
                             6'(pos + 6'h01), 1'b1)}; // RL3 RL25
        end else if (idx >= IDP_FW_W0 && idx <= IDP_FW_WN) begin
            pos = 6'({idx - IDP_FW_W0, 1'b0});
            word = {fld_char({256'h0, str.fw}, str.fw_len, IDP_FW_LEN, pos, 1'b0),
                    fld_char({256'h0, str.fw}, str.fw_len, IDP_FW_LEN,
                             6'(pos + 6'h01), 1'b0)}; // RL4 RL25
        end else if (idx >= IDP_MODEL_W0 && idx <= IDP_MODEL_WN) begin
            pos = 6'({idx - IDP_MODEL_W0, 1'b0});
            word = {fld_char(str.model, str.model_len, IDP_MODEL_LEN, pos, 1'b0),
                    fld_char(str.model, str.model_len, IDP_MODEL_LEN,
                             6'(pos + 6'h01), 1'b0)}; // RL5 RL25
        end else begin
            case (idx)
                8'd0: word = IDP_W0_CONFIG; // RL1
                8'd1: word = IDP_W1_CYLS; // RL2
                8'd3: word = IDP_W3_HEADS; // RL2
                8'd6: word = IDP_W6_SPT; // RL2
                8'd20: word = IDP_W20_OLD;
                8'd21: word = IDP_W21_BUFSZ; // RL6
                8'd22: word = IDP_W22_ECC; // RL6
                8'd47: word = IDP_W47_MULTMAX; // RL7
                8'd49: word = IDP_W49_CAPS; // RL8
                8'd50: word = IDP_W50_CAPS;
                8'd51: word = IDP_W51_PIO; // RL9
                8'd52: word = IDP_W52_SWDMA; // RL9
                8'd53: word = IDP_W53_VALID; // RL10
                8'd54: word = cfg.cur_cyl; // RL11
                8'd55: word = cfg.cur_head; // RL11
                8'd56: word = cfg.cur_spt; // RL11
                8'd57: word = cfg.cur_cap[15:0]; // RL11
                8'd58: word = cfg.cur_cap[31:16]; // RL11
                8'd59: word = is_multi_ok ? {8'h01, cfg.multi_cnt} : 16'h0000; // RL12
                8'd60: word = cfg.lba_cap[15:0]; // RL13
                8'd61: word = cfg.lba_cap[31:16]; // RL13
                8'd63: begin
                    word = {8'h00, IDP_W63_MDMA_SUP}; // RL14
                    if (cfg.mdma_en && cfg.mdma_mode <= 2'd2) begin
                        word[8 + 32'(cfg.mdma_mode)] = 1'b1; // RL22
                    end
                end
                8'd64: word = IDP_W64_APIO; // RL15
                8'd65: word = IDP_W65_MDMA_MIN; // RL16
                8'd66: word = IDP_W66_MDMA_REC; // RL16
                8'd67: word = IDP_W67_PIO_NOFC; // RL17
                8'd68: word = IDP_W68_PIO_FC; // RL17
                8'd80: word = IDP_W80_MAJOR; // RL18
                8'd81: word = IDP_W81_MINOR; // RL18
                8'd82: word = IDP_W82_CMDSET; // RL19
                8'd83: word = IDP_W83_CMDSET; // RL19
                8'd84: word = IDP_W84_EXT; // RL19
                8'd87: word = IDP_W87_DEFAULT; // RL19
                8'd88: begin
                    word = {8'h00, IDP_W88_UDMA_SUP}; // RL23
                    if (cfg.udma_en && cfg.udma_mode <= 3'd5) begin
                        word[8 + 32'(cfg.udma_mode)] = 1'b1; // RL23
                    end
                end
                8'd89: word = cfg.erase_time; // RL20
                8'd90: word = IDP_W90_ENH_ERASE; // RL20
                8'd91: word = {8'h00, cfg.apm_level}; // RL20
                default: word = 16'h0000; // RL24
            endcase
        end
    end
endmodule

/* File: testbench/idp_host_model.sv */
`timescale 1ns/1ns
module idp_host_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // device status
    input wire logic irq,
    // behaviour
    input wire logic slow,
    input wire logic poke,
    // word read
    output logic rd_req
);
    int left;

    initial begin
        rd_req = 1'b0;
        left = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // reads the whole page once the interrupt shows, stalling at random
    always @(posedge sys_clk) begin
        #2;
        if (sys_rst) begin
            left = 0;
            rd_req = 1'b0;
        end else begin
            if (rd_req && left != 0) left = left - 1;
            if (irq) left = 256;
            // poke makes a stray read that the idle device must ignore
            rd_req = poke || (left != 0 && !(slow && $urandom_range(0, 2) == 0));
        end
    end
endmodule

/* File: testbench/idp_top_test.sv */
`timescale 1ns/1ns
module idp_top_test;
    import idp_pkg::*;

    logic sys_clk;
    logic sys_rst;
    logic cmd_valid;
    logic [7:0] cmd_code;
    idp_cfg_s cfg;
    idp_str_s str;
    logic rd_req;
    logic [15:0] rd_data;
    logic rd_valid;
    logic busy;
    logic drq;
    logic irq;
    logic slow;
    logic poke;
    int err_total;
    int cmp_count;
    logic [15:0] exp_q[$];

    idp_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cfg(cfg), .str(str), .rd_req(rd_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy(busy), .drq(drq), .irq(irq));

    idp_host_model host (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq(irq), .slow(slow),
        .poke(poke), .rd_req(rd_req));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // expected page, built straight from the field layout
    function automatic logic [7:0] str_char(input int f, input int p);
        int w;
        int n;
        w = (f == 0) ? 20 : (f == 1) ? 8 : 40;
        n = (f == 0) ? str.serial_len : (f == 1) ? str.fw_len : str.model_len;
        if (n > w) n = w;
        if (f == 0) begin
            if (p < w - n) return 8'h20;
            return str.serial[8*(p-(w-n)) +: 8];
        end
        if (p >= n) return 8'h20;
        return (f == 1) ? str.fw[8*p +: 8] : str.model[8*p +: 8];
    endfunction

    function automatic logic [15:0] exp_word(input int n);
        logic [15:0] v;
        logic [2:0] ms;
        logic [5:0] us;
        int f;
        int p;
        v = 16'h0000;
        ms = (cfg.mdma_en && cfg.mdma_mode != 2'h3) ? 3'h1 << cfg.mdma_mode : 3'h0;
        us = (cfg.udma_en && cfg.udma_mode < 3'h6) ? 6'h01 << cfg.udma_mode : 6'h00;
        f = (n >= 10 && n <= 19) ? 0 : (n >= 23 && n <= 26) ? 1 : (n >= 27 && n <= 46) ? 2 : -1;
        p = (f == 0) ? 2*(n-10) : (f == 1) ? 2*(n-23) : 2*(n-27);
        if (f >= 0) return {str_char(f, p), str_char(f, p + 1)};
        case (n)
            0: v = 16'h045a;
            1: v = 16'h3fff;
            3: v = 16'h0010;
            6: v = 16'h003f;
            20: v = 16'h0003;
            21: v = 16'h0400;
            22: v = 16'h0004;
            47: v = 16'h8010;
            49: v = 16'h2b00;
            50: v = 16'h4000;
            51, 52: v = 16'h0200;
            53: v = 16'h0007;
            54: v = cfg.cur_cyl;
            55: v = cfg.cur_head;
            56: v = cfg.cur_spt;
            57: v = cfg.cur_cap[15:0];
            58: v = cfg.cur_cap[31:16];
            59: if (cfg.multi_cnt inside {8'h02, 8'h04, 8'h08, 8'h10})
                v = {8'h01, cfg.multi_cnt};
            60: v = cfg.lba_cap[15:0];
            61: v = cfg.lba_cap[31:16];
            63: v = {5'h00, ms, 8'h07};
            64: v = 16'h0003;
            65, 66, 68: v = 16'h0078;
            67: v = 16'h00f0;
            80: v = 16'h003e;
            81: v = 16'h0015;
            82: v = 16'h346b;
            83: v = 16'h4108;
            84, 87: v = 16'h4000;
            88: v = {2'h0, us, 2'h0, 6'h3f};
            89: v = cfg.erase_time;
            91: v = {8'h00, cfg.apm_level};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one compare per delivered word, oldest note first
    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                fail("word delivered without an accepted read");
            else
                chk(rd_data, exp_q.pop_front(), "page word");
        end
    end

    task automatic refuse_test();
        logic [7:0] codes [5] = '{8'h00, 8'h91, 8'hed, 8'h6c, 8'hff};
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            #2 cmd_valid = 1'b1;
            cmd_code = codes[i];
            poke = 1'b1;
        end
        @(posedge sys_clk);
        #2 cmd_valid = 1'b0;
        poke = 1'b0;
        repeat (3) begin
            @(posedge sys_clk);
            #2 chk({14'h0, drq, busy}, 16'h0000, "other codes ignored");
        end
        $display("test refuse done");
    endtask

    task automatic identify(input int r);
        logic [159:0] rb;
        logic [7:0] mlist [8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h03, 8'h20, 8'h01};
        int i;
        rb = {$urandom, $urandom, $urandom, $urandom, $urandom};
        cfg = rb[$bits(idp_cfg_s)-1:0];
        cfg.mdma_en = (r != 5);
        cfg.mdma_mode = 2'(r);
        cfg.udma_en = (r != 4);
        cfg.udma_mode = 3'(r);
        cfg.multi_cnt = mlist[r];
        for (i = 0; i < 60; i++) begin
            if (i < 40) str.model[8*i +: 8] = 8'($urandom_range(33, 126));
            if (i < 20) str.serial[8*i +: 8] = 8'($urandom_range(33, 126));
            if (i < 8) str.fw[8*i +: 8] = 8'($urandom_range(33, 126));
        end
        str.model_len = 6'($urandom_range(0, 45));
        str.serial_len = 6'($urandom_range(0, 22));
        str.fw_len = 6'($urandom_range(0, 10));
        slow = r[0];
        for (i = 0; i < 256; i++) exp_q.push_back(exp_word(i));
        @(posedge sys_clk);
        #2 cmd_valid = 1'b1;
        cmd_code = IDP_CMD_IDENTIFY;
        @(posedge sys_clk);
        #2 cmd_valid = 1'b0;
        chk({14'h0, drq, busy}, 16'h0001, "busy after command");
        for (i = 0; i < 255; i++) begin
            @(posedge sys_clk);
            // a repeat command while busy must not restart the fill
            #2 cmd_valid = (i == 100);
            chk({14'h0, drq, busy}, 16'h0001, "busy while filling");
        end
        @(posedge sys_clk);
        #2 chk({13'h0, irq, drq, busy}, 16'h0006, "page ready");
        @(posedge sys_clk);
        #2 chk({13'h0, irq, drq, busy}, 16'h0002, "interrupt lasts one cycle");
        repeat (4) @(posedge sys_clk);
        #2 cmd_valid = 1'b1;
        @(posedge sys_clk);
        #2 cmd_valid = 1'b0;
        i = 0;
        while (drq === 1'b1 && i < 2000) begin
            @(posedge sys_clk);
            #2 i++;
        end
        @(posedge sys_clk);
        #2 chk(16'(exp_q.size()), 16'h0000, "whole page read");
        chk({14'h0, drq, busy}, 16'h0000, "idle after page");
        $display("test identify %0d done", r);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cfg = '0;
        str = '0;
        slow = 1'b0;
        poke = 1'b0;
        err_total = 0;
        cmp_count = 0;
        void'($urandom(96317));
        repeat (20) @(posedge sys_clk);
        #2 sys_rst = 1'b0;
        chk({12'h0, rd_valid, irq, drq, busy}, 16'h0000, "status after reset");
        chk(rd_data, 16'h0000, "data after reset");
        $display("test reset done");
        refuse_test();
        for (int r = 0; r < 8; r++) identify(r);
        final_report();
    end

    // whole run needs about 4700 cycles
    initial begin
        #(40000 * 50);
        fail("run did not finish in time");
        final_report();
    end
endmodule
